// ---- fgpio_chk.sv ----
// checker for the gpio block: apb handshake, pin routing, irq line
// assumes it is bound to fgpio_top and sees only its ports
`timescale 1ns/100ps
module fgpio_chk #(
  parameter int NP = 3,
  parameter int PW = 32
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire fgpio_pkg::fgpio_addr_t paddr,
  input wire fgpio_pkg::fgpio_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and routing
  input wire logic [NP-1:0][PW-1:0] pin_out,
  input wire logic [NP-1:0][PW-1:0] pin_oe_n,
  input wire logic [NP-1:0][PW-1:0] periph_sel,
  input wire logic [NP-1:0][PW-1:0] periph_out,
  input wire logic [NP-1:0][PW-1:0] periph_oe,
  // interrupt
  input wire logic ext_irq3_in,
  input wire logic shared_ext_irq_line
);
  import fgpio_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_wait;
    psel && penable && !pready && ce;
  endsequence
  sequence acc_done;
    psel && penable && pready;
  endsequence
  // held inputs across two edges, so the one-cycle lag has settled
  sequence route_held;
    $stable(periph_sel) && $stable(periph_oe) && $stable(periph_out) && $past(ce)
      && $past(presetn);
  endsequence
  rdy_wait_a: assert property (acc_wait |=> pready)
    else $error("pready missing after first access cycle");
  rdy_pulse_a: assert property (pready && ce |=> !pready)
    else $error("pready stood longer than one cycle");
  rdy_bus_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_data_a: assert property (pslverr |-> pready && prdata == '0)
    else $error("pslverr without pready or with data");
  err_map_a: assert property ((acc_done and paddr >= 12'h0E0) |-> pslverr)
    else $error("unmapped address answered without pslverr");
  idle_data_a: assert property (!pready |-> prdata == '0)
    else $error("prdata nonzero outside answer");
  oe_route_a: assert property (route_held |->
      (pin_oe_n & periph_sel) == (~periph_oe & periph_sel))
    else $error("peripheral pin enable not followed");
  out_route_a: assert property (route_held |->
      (pin_out & periph_sel) == (periph_out & periph_sel))
    else $error("peripheral pin value not followed");
  rst_pins_a: assert property ($rose(presetn) |->
      (&pin_oe_n) && pin_out == '0 && !pready)
    else $error("pins not inputs right after reset");
  irq_ext_a: assert property (ext_irq3_in && $past(ext_irq3_in) && $past(ce)
      && $past(presetn) |-> shared_ext_irq_line)
    else $error("external request not on shared line");
endmodule
bind fgpio_top fgpio_chk #(.NP(NP), .PW(PW)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_sel(periph_sel),
  .periph_out(periph_out), .periph_oe(periph_oe), .ext_irq3_in(ext_irq3_in),
  .shared_ext_irq_line(shared_ext_irq_line)
);

// ---- fgpio_edge.sv ----
// edge capture for one interrupt-capable port
// pin edges toggle flops with no clock; pclk side syncs and latches
`timescale 1ns/100ps
module fgpio_edge #(
  parameter int W = 32,
  parameter logic [W-1:0] CAP = '1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // raw pins, enables and write-one clear
  input wire logic [W-1:0] pin_raw,
  input wire logic [W-1:0] rise_en,
  input wire logic [W-1:0] fall_en,
  input wire logic [W-1:0] clr,
  // sticky status and clockless wake
  output logic [W-1:0] rise_stat_reg,
  output logic [W-1:0] fall_stat_reg,
  output logic wake
);
  logic [W-1:0] rtog;
  logic [W-1:0] ftog;
  logic [W-1:0] r_s1_reg, r_s2_reg, r_seen_reg;
  logic [W-1:0] f_s1_reg, f_s2_reg, f_seen_reg;
  logic [W-1:0] r_ev, f_ev;

  // toggles flip on the pin itself, so edges count with pclk stopped
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (CAP[i]) begin : g_cap
      // one flop per bit and process, so each toggle has a single writer
      logic rt_reg;
      logic ft_reg;
      always_ff @(posedge pin_raw[i] or negedge presetn) begin
        if (!presetn) rt_reg <= 1'b0;
        else rt_reg <= ~rt_reg; // RQ8 RQ9
      end
      always_ff @(negedge pin_raw[i] or negedge presetn) begin
        if (!presetn) ft_reg <= 1'b0;
        else ft_reg <= ~ft_reg; // RQ8 RQ9
      end
      assign rtog[i] = rt_reg;
      assign ftog[i] = ft_reg;
    end else begin : g_nocap
      assign rtog[i] = 1'b0;
      assign ftog[i] = 1'b0;
    end
  end

  assign r_ev = (r_s2_reg ^ r_seen_reg) & rise_en & CAP;
  assign f_ev = (f_s2_reg ^ f_seen_reg) & fall_en & CAP;
  // unsynchronised on purpose: the power controller reads it, as does wake_reg in the top
  assign wake = |(((rtog ^ r_seen_reg) & rise_en) | ((ftog ^ f_seen_reg) & fall_en)); // RQ10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_s1_reg <= '0;
      r_s2_reg <= '0;
      r_seen_reg <= '0;
      f_s1_reg <= '0;
      f_s2_reg <= '0;
      f_seen_reg <= '0;
      rise_stat_reg <= '0;
      fall_stat_reg <= '0;
    end else if (ce) begin
      r_s1_reg <= rtog;
      r_s2_reg <= r_s1_reg;
      r_seen_reg <= r_s2_reg;
      f_s1_reg <= ftog;
      f_s2_reg <= f_s1_reg;
      f_seen_reg <= f_s2_reg;
      rise_stat_reg <= (rise_stat_reg & ~clr) | r_ev; // RQ14
      fall_stat_reg <= (fall_stat_reg & ~clr) | f_ev; // RQ14
    end
  end
endmodule

// ---- fgpio_pins.sv ----
// pad model: the port pins with far-side sources
// assumes active-low output enables from the block
`timescale 1ns/100ps
module fgpio_pins (
  // block side
  input wire logic [2:0][31:0] pin_out,
  input wire logic [2:0][31:0] pin_oe_n,
  // far-side sources
  input wire logic [2:0][31:0] ext_drv,
  output logic [2:0][31:0] pin_in
);
  // undriven bits show the far source, never a held value
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_drv & pin_oe_n);
endmodule

// ---- fgpio_pkg.sv ----
// fast gpio port block: register map, field layout and reset values
// assumes a 32-bit apb slave with a 12-bit byte address window
package fgpio_pkg;
  localparam int FGPIO_NP = 3;
  localparam int FGPIO_PW = 32;
  localparam int FGPIO_AW = 12;
  typedef logic [FGPIO_PW-1:0] fgpio_word_t;
  typedef logic [FGPIO_AW-1:0] fgpio_addr_t;

  // fast register bank, one per port, port p at p * FGPIO_PORT_STRIDE
  localparam fgpio_addr_t FGPIO_PORT_STRIDE = 12'h020;
  localparam logic [4:0] FGPIO_OFS_DIR = 5'h00;
  localparam logic [4:0] FGPIO_OFS_MASK = 5'h10;
  localparam logic [4:0] FGPIO_OFS_PIN = 5'h14;
  localparam logic [4:0] FGPIO_OFS_SET = 5'h18;
  localparam logic [4:0] FGPIO_OFS_CLR = 5'h1C;

  // edge interrupt banks: port 0 at 0x080, port 2 at 0x0A0
  localparam fgpio_addr_t FGPIO_IRQ_BASE = 12'h080;
  localparam logic [4:0] FGPIO_OFS_IRQ_STAT = 5'h00;
  localparam logic [4:0] FGPIO_OFS_RISE_STAT = 5'h04;
  localparam logic [4:0] FGPIO_OFS_FALL_STAT = 5'h08;
  localparam logic [4:0] FGPIO_OFS_EDGE_CLR = 5'h0C;
  localparam logic [4:0] FGPIO_OFS_RISE_EN = 5'h10;
  localparam logic [4:0] FGPIO_OFS_FALL_EN = 5'h14;
  localparam int FGPIO_IRQ_STAT_P0 = 0;
  localparam int FGPIO_IRQ_STAT_P2 = 2;

  // legacy alias of ports 0 and 1, no mask applied
  localparam fgpio_addr_t FGPIO_LEG_BASE = 12'h0C0;
  localparam logic [3:0] FGPIO_LEG_PIN = 4'h0;
  localparam logic [3:0] FGPIO_LEG_SET = 4'h4;
  localparam logic [3:0] FGPIO_LEG_DIR = 4'h8;
  localparam logic [3:0] FGPIO_LEG_CLR = 4'hC;

  // reset values
  localparam fgpio_word_t FGPIO_DIR_RST = 32'h0000_0000;
  localparam fgpio_word_t FGPIO_MASK_RST = 32'h0000_0000;
  localparam fgpio_word_t FGPIO_OUT_RST = 32'h0000_0000;
  localparam fgpio_word_t FGPIO_EN_RST = 32'h0000_0000;
  localparam fgpio_word_t FGPIO_OE_N_RST = 32'hFFFF_FFFF;
  localparam fgpio_word_t FGPIO_CAP0 = 32'hFFFF_FFFF;
  localparam fgpio_word_t FGPIO_CAP2 = 32'h0000_03FF;
endpackage

// ---- fgpio_port.sv ----
// one port: direction, mask and output registers with lane writes
// assumes the top decodes addresses and hands over one-cycle strobes
`timescale 1ns/100ps
module fgpio_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // write strobes
  input wire logic wr_dir,
  input wire logic wr_mask,
  input wire logic wr_pin,
  input wire logic wr_set,
  input wire logic wr_clr,
  input wire logic no_mask,
  // write data and lane mask
  input wire fgpio_pkg::fgpio_word_t wdata,
  input wire fgpio_pkg::fgpio_word_t lane_mask,
  // register state
  output fgpio_pkg::fgpio_word_t dir_reg,
  output fgpio_pkg::fgpio_word_t mask_reg,
  output fgpio_pkg::fgpio_word_t out_reg
);
  import fgpio_pkg::*;

  fgpio_word_t eff;
  fgpio_word_t dir_next;
  fgpio_word_t mask_next;
  fgpio_word_t out_next;

  assign eff = lane_mask & ~(no_mask ? '0 : mask_reg); // RQ5 RQ6
  assign dir_next = (dir_reg & ~lane_mask) | (wdata & lane_mask); // RQ2 RQ6
  assign mask_next = (mask_reg & ~lane_mask) | (wdata & lane_mask);
  assign out_next = wr_pin ? ((out_reg & ~eff) | (wdata & eff)) : // RQ7
                    wr_set ? (out_reg | (wdata & eff)) : // RQ3
                    wr_clr ? (out_reg & ~(wdata & eff)) : out_reg; // RQ3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= FGPIO_DIR_RST; // RQ11
      mask_reg <= FGPIO_MASK_RST;
      out_reg <= FGPIO_OUT_RST;
    end else if (ce) begin
      if (wr_dir) dir_reg <= dir_next;
      if (wr_mask) mask_reg <= mask_next;
      out_reg <= out_next;
    end
  end
endmodule

// ---- fgpio_top.sv ----
// fast gpio port block with apb register access and pin edge interrupts
// assumes apb master, pins synchronous to pclk except edge capture
// Operation
// RQ1: peripheral-owned pins ignore port registers
// RQ2: per-bit direction, writable any time
// RQ3: set and clear writes touch ones only
// RQ4: read output register and live pins separately
// RQ5: mask limits port writes and pin reads
// RQ6: byte and half-word accesses per lane
// RQ7: one full-width write sets whole port
// RQ8: per-pin rising, falling or both edges
// RQ9: edge capture needs no running clock
// RQ10: enabled edge requests power-down wake
// RQ11: all pins inputs after reset
// RQ12: legacy alias of ports 0 and 1
// RQ13: edge requests ORed onto shared line
// RQ14: sticky per-pin edge status, write-one clear
`timescale 1ns/100ps
module fgpio_top #(
  parameter int NP = fgpio_pkg::FGPIO_NP,
  parameter int PW = fgpio_pkg::FGPIO_PW
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire fgpio_pkg::fgpio_addr_t paddr,
  input wire fgpio_pkg::fgpio_word_t pwdata,
  input wire logic [3:0] pstrb,
  output fgpio_pkg::fgpio_word_t prdata,
  output logic pready,
  output logic pslverr,
  // port pins
  input wire logic [NP-1:0][PW-1:0] pin_in,
  output logic [NP-1:0][PW-1:0] pin_out,
  output logic [NP-1:0][PW-1:0] pin_oe_n,
  // peripheral function routing
  input wire logic [NP-1:0][PW-1:0] periph_sel,
  input wire logic [NP-1:0][PW-1:0] periph_out,
  input wire logic [NP-1:0][PW-1:0] periph_oe,
  // interrupt and wake
  input wire logic ext_irq3_in,
  output logic shared_ext_irq_line,
  output logic wake_req
);
  import fgpio_pkg::*;

  // bus handshake
  logic pready_reg;
  logic pslverr_reg;
  fgpio_word_t prdata_reg;
  logic access;
  logic wr_go;
  fgpio_word_t lane_mask;

  // address decode
  logic [4:0] ofs;
  logic [NP-1:0] port_hit;
  logic irq_hit;
  logic irq_bank;
  logic leg_hit;
  logic leg_port;
  logic [3:0] leg_ofs;
  logic addr_ok;

  // per-port strobes and state
  logic [NP-1:0] wr_dir, wr_mask, wr_pin, wr_set, wr_clr, no_mask;
  fgpio_word_t dir_q [NP];
  fgpio_word_t mask_q [NP];
  fgpio_word_t out_q [NP];
  logic [NP-1:0][PW-1:0] pin_smp_reg;
  logic [NP-1:0][PW-1:0] pin_out_reg;
  logic [NP-1:0][PW-1:0] pin_oe_n_reg;

  // edge interrupt state, index 0 is port 0, index 1 is port 2
  fgpio_word_t rise_en_reg [2];
  fgpio_word_t fall_en_reg [2];
  fgpio_word_t rise_st [2];
  fgpio_word_t fall_st [2];
  fgpio_word_t edge_clr [2];
  logic [1:0] wr_ren, wr_fen, wr_eclr;
  logic [1:0] edge_wake;
  logic [1:0] bank_pend;
  logic irq_reg;
  logic wake_reg;
  fgpio_word_t rd_next;

  assign access = psel & penable & ce;
  // write lands at the edge where pready is seen high
  assign wr_go = access & pwrite & pready_reg;
  assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}; // RQ6

  assign ofs = paddr[4:0];
  assign irq_hit = (paddr[11:6] == FGPIO_IRQ_BASE[11:6]);
  assign irq_bank = paddr[5];
  assign leg_hit = (paddr[11:5] == FGPIO_LEG_BASE[11:5]);
  assign leg_port = paddr[4];
  assign leg_ofs = paddr[3:0];

  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam logic [6:0] PIDX = 7'(p);
    logic is_leg;
    assign port_hit[p] = (paddr[11:5] == PIDX);
    assign is_leg = (p < 2) && leg_hit && (leg_port == PIDX[0]); // RQ12
    assign no_mask[p] = is_leg;
    assign wr_dir[p] = wr_go & ((port_hit[p] & (ofs == FGPIO_OFS_DIR)) |
                                (is_leg & (leg_ofs == FGPIO_LEG_DIR)));
    assign wr_mask[p] = wr_go & port_hit[p] & (ofs == FGPIO_OFS_MASK);
    assign wr_pin[p] = wr_go & port_hit[p] & (ofs == FGPIO_OFS_PIN);
    assign wr_set[p] = wr_go & ((port_hit[p] & (ofs == FGPIO_OFS_SET)) |
                                (is_leg & (leg_ofs == FGPIO_LEG_SET)));
    assign wr_clr[p] = wr_go & ((port_hit[p] & (ofs == FGPIO_OFS_CLR)) |
                                (is_leg & (leg_ofs == FGPIO_LEG_CLR)));

    fgpio_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .wr_dir(wr_dir[p]),
      .wr_mask(wr_mask[p]),
      .wr_pin(wr_pin[p]),
      .wr_set(wr_set[p]),
      .wr_clr(wr_clr[p]),
      .no_mask(no_mask[p]),
      .wdata(pwdata),
      .lane_mask(lane_mask),
      .dir_reg(dir_q[p]),
      .mask_reg(mask_q[p]),
      .out_reg(out_q[p])
    );
  end

  // interrupt bank strobes, bank 0 is port 0, bank 1 is port 2
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic hit;
    assign hit = wr_go & irq_hit & (irq_bank == 1'(b));
    assign wr_ren[b] = hit & (ofs == FGPIO_OFS_RISE_EN);
    assign wr_fen[b] = hit & (ofs == FGPIO_OFS_FALL_EN);
    assign wr_eclr[b] = hit & (ofs == FGPIO_OFS_EDGE_CLR);
    assign edge_clr[b] = wr_eclr[b] ? (pwdata & lane_mask) : '0; // RQ14
    assign bank_pend[b] = |((rise_st[b] & rise_en_reg[b]) |
                            (fall_st[b] & fall_en_reg[b])); // RQ14

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rise_en_reg[b] <= FGPIO_EN_RST;
        fall_en_reg[b] <= FGPIO_EN_RST;
      end else if (ce) begin
        if (wr_ren[b])
          rise_en_reg[b] <= (rise_en_reg[b] & ~lane_mask) | (pwdata & lane_mask); // RQ8
        if (wr_fen[b])
          fall_en_reg[b] <= (fall_en_reg[b] & ~lane_mask) | (pwdata & lane_mask); // RQ8
      end
    end
  end

  fgpio_edge #(
    .W(PW),
    .CAP(FGPIO_CAP0)
  ) u_edge0 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_raw(pin_in[0]),
    .rise_en(rise_en_reg[0]),
    .fall_en(fall_en_reg[0]),
    .clr(edge_clr[0]),
    .rise_stat_reg(rise_st[0]),
    .fall_stat_reg(fall_st[0]),
    .wake(edge_wake[0])
  );

  fgpio_edge #(
    .W(PW),
    .CAP(FGPIO_CAP2)
  ) u_edge2 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_raw(pin_in[2]),
    .rise_en(rise_en_reg[1]),
    .fall_en(fall_en_reg[1]),
    .clr(edge_clr[1]),
    .rise_stat_reg(rise_st[1]),
    .fall_stat_reg(fall_st[1]),
    .wake(edge_wake[1])
  );

  // every decoded offset, anything else answers with pslverr
  assign addr_ok =
    ((paddr[11:5] < 7'(NP)) &&
     ((ofs == FGPIO_OFS_DIR) || (ofs == FGPIO_OFS_MASK) || (ofs == FGPIO_OFS_PIN) ||
      (ofs == FGPIO_OFS_SET) || (ofs == FGPIO_OFS_CLR))) ||
    (irq_hit && (ofs <= FGPIO_OFS_FALL_EN) && (ofs[1:0] == 2'b00)) ||
    (leg_hit && (leg_ofs[1:0] == 2'b00));

  // read mux
  always_comb begin
    logic [6:0] pi;
    logic bk;
    pi = paddr[11:5];
    bk = irq_bank;
    rd_next = '0;
    if (irq_hit) begin
      case (ofs)
        FGPIO_OFS_IRQ_STAT: begin
          rd_next[FGPIO_IRQ_STAT_P0] = bank_pend[0];
          rd_next[FGPIO_IRQ_STAT_P2] = bank_pend[1];
        end
        FGPIO_OFS_RISE_STAT: rd_next = rise_st[bk];
        FGPIO_OFS_FALL_STAT: rd_next = fall_st[bk];
        FGPIO_OFS_RISE_EN: rd_next = rise_en_reg[bk];
        FGPIO_OFS_FALL_EN: rd_next = fall_en_reg[bk];
        default: rd_next = '0;
      endcase
    end else if (leg_hit) begin
      case (leg_ofs)
        FGPIO_LEG_PIN: rd_next = pin_smp_reg[leg_port]; // RQ12
        FGPIO_LEG_SET: rd_next = out_q[leg_port];
        FGPIO_LEG_DIR: rd_next = dir_q[leg_port];
        default: rd_next = '0;
      endcase
    end else if (pi < 7'(NP)) begin
      case (ofs)
        FGPIO_OFS_DIR: rd_next = dir_q[pi[1:0]];
        FGPIO_OFS_MASK: rd_next = mask_q[pi[1:0]];
        FGPIO_OFS_PIN: rd_next = pin_smp_reg[pi[1:0]] & ~mask_q[pi[1:0]]; // RQ4 RQ5
        FGPIO_OFS_SET: rd_next = out_q[pi[1:0]]; // RQ4
        default: rd_next = '0;
      endcase
    end
  end

  // one wait state: pready rises at the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (ce) begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~addr_ok;
      prdata_reg <= (access & ~pready_reg & ~pwrite) ? rd_next : '0;
    end
  end

  // pin side: peripheral routing wins over port registers
  for (genvar p = 0; p < NP; p++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_smp_reg[p] <= '0;
        pin_out_reg[p] <= FGPIO_OUT_RST;
        pin_oe_n_reg[p] <= FGPIO_OE_N_RST; // RQ11
      end else if (ce) begin
        pin_smp_reg[p] <= pin_in[p]; // RQ4
        pin_out_reg[p] <= (periph_sel[p] & periph_out[p]) |
                          (~periph_sel[p] & out_q[p]); // RQ1
        pin_oe_n_reg[p] <= ~((periph_sel[p] & periph_oe[p]) |
                             (~periph_sel[p] & dir_q[p])); // RQ1 RQ2
      end
    end
  end

  // shared line and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= bank_pend[0] | bank_pend[1] | ext_irq3_in; // RQ13
      wake_reg <= |edge_wake;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign shared_ext_irq_line = irq_reg;
  // with pclk stopped the clockless term must still reach the power controller
  assign wake_req = wake_reg | (|edge_wake); // RQ10
endmodule

// ---- fgpio_top_tb_top.sv ----
// testbench for the gpio block: apb master, pad model, edge events
// assumes the one-wait-state apb slave and map of fgpio_pkg
`timescale 1ns/100ps
module fgpio_top_tb_top;
  import fgpio_pkg::*;
  logic pclk = 0, presetn = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irq, wake, hi, ext_irq = 0;
  logic [3:0] pstrb = 4'hF;
  fgpio_addr_t paddr = '0;
  fgpio_word_t pwdata = '0, prdata, v, o, m, x, w;
  logic [2:0][31:0] pin_in, pin_out, pin_oe_n, ext_drv = '0;
  logic [2:0][31:0] psel_m = '0, pout = '0, poe = '0;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int n_errors = 0, cmp_count = 0, cyc = 0, pt, seed = 32'h2c45;
  always #10 pclk = ~pclk;
  fgpio_top u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .periph_sel(psel_m), .periph_out(pout), .periph_oe(poe),
    .ext_irq3_in(ext_irq), .shared_ext_irq_line(irq), .wake_req(wake)
  );
  fgpio_pins u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drv(ext_drv),
    .pin_in(pin_in));
  task automatic chk(input string s, input fgpio_word_t a, input fgpio_word_t b);
    cmp_count++;
    if (a !== b) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, a, b);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // request held until the edge that samples pready high
  task automatic xfer(input logic wr, input fgpio_addr_t a, input fgpio_word_t d,
      input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle, release only after the edge that samples pready high
    do begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr32(input fgpio_addr_t a, input fgpio_word_t d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rd32(input fgpio_addr_t a, input logic er, input fgpio_word_t d);
    exp_q.push_back({er, d});
    xfer(1'b0, a, '0, 4'h0);
  endtask
  function automatic fgpio_addr_t pa(input int p, input logic [4:0] ofs);
    return fgpio_addr_t'(p) * FGPIO_PORT_STRIDE + ofs;
  endfunction
  function automatic fgpio_addr_t ea(input logic p2, input logic [4:0] ofs);
    return FGPIO_IRQ_BASE + (p2 ? 12'h020 : 12'h000) + ofs;
  endfunction
  // read answers checked against the oldest note, mid-cycle where settled
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      chk("rdata", e[31:0], prdata);
      chk("pslverr", e[32], pslverr);
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    // a real falling edge so the clockless toggles see their reset
    presetn <= 1'b0;
    tick(10);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe_n", 1'b1, &pin_oe_n);
    chk("out", 1'b0, |pin_out);
    for (int p = 0; p < 3; p++) begin
      rd32(pa(p, FGPIO_OFS_DIR), 1'b0, FGPIO_DIR_RST);
      w = $random(seed);
      wr32(pa(p, FGPIO_OFS_DIR), w);
      rd32(pa(p, FGPIO_OFS_DIR), 1'b0, w);
      wr32(pa(p, FGPIO_OFS_DIR), '0);
    end
    $display("test dir done");
    v = $random(seed);
    x = $random(seed);
    ext_drv[1] <= x;
    wr32(pa(1, FGPIO_OFS_DIR), v);
    xfer(1'b1, pa(1, FGPIO_OFS_DIR), ~v, 4'h2);
    xfer(1'b1, pa(1, FGPIO_OFS_DIR), ~v, 4'hC);
    v = v ^ 32'hFFFF_FF00;
    rd32(pa(1, FGPIO_OFS_DIR), 1'b0, v);
    w = $random(seed);
    m = $random(seed);
    wr32(pa(1, FGPIO_OFS_SET), w);
    wr32(pa(1, FGPIO_OFS_CLR), m);
    o = w & ~m;
    rd32(pa(1, FGPIO_OFS_SET), 1'b0, o);
    chk("oe_n", ~v, pin_oe_n[1]);
    chk("out", o & v, pin_out[1] & v);
    rd32(pa(1, FGPIO_OFS_PIN), 1'b0, (o & v) | (x & ~v));
    m = $random(seed);
    w = $random(seed);
    wr32(pa(1, FGPIO_OFS_MASK), m);
    wr32(pa(1, FGPIO_OFS_PIN), w);
    o = (o & m) | (w & ~m);
    rd32(pa(1, FGPIO_OFS_SET), 1'b0, o);
    rd32(pa(1, FGPIO_OFS_PIN), 1'b0, ((o & v) | (x & ~v)) & ~m);
    rd32(FGPIO_LEG_BASE + 12'h010 + FGPIO_LEG_PIN, 1'b0, (o & v) | (x & ~v));
    $display("test port done");
    w = $random(seed);
    psel_m[1] <= w;
    pout[1] <= x ^ o;
    poe[1] <= m;
    tick(3);
    chk("oe_n", ~m & w, pin_oe_n[1] & w);
    chk("out", (x ^ o) & w, pin_out[1] & w);
    chk("oe_n", ~v & ~w, pin_oe_n[1] & ~w);
    psel_m[1] <= '0;
    w = $random(seed);
    wr32(FGPIO_LEG_BASE + FGPIO_LEG_SET, w);
    rd32(pa(0, FGPIO_OFS_SET), 1'b0, w);
    wr32(FGPIO_LEG_BASE + FGPIO_LEG_CLR, w);
    wr32(FGPIO_LEG_BASE + 12'h010 + FGPIO_LEG_DIR, '0);
    rd32(pa(1, FGPIO_OFS_DIR), 1'b0, '0);
    $display("test legacy done");
    // rise only, fall only (port 2 bit 9, its top captured bit), both edges
    for (int i = 0; i < 3; i++) begin
      pt = (i == 1) ? 2 : 0;
      hi = (i == 1);
      w = 32'h1 << ((i == 1) ? 9 : 5 * i);
      wr32(ea(hi, FGPIO_OFS_RISE_EN), (i != 1) ? w : '0);
      wr32(ea(hi, FGPIO_OFS_FALL_EN), (i != 0) ? w : '0);
      ext_drv[pt] <= w;
      tick(6);
      ext_drv[pt] <= '0;
      tick(6);
      chk("irq", 1'b1, irq);
      rd32(ea(hi, FGPIO_OFS_RISE_STAT), 1'b0, (i != 1) ? w : '0);
      rd32(ea(hi, FGPIO_OFS_FALL_STAT), 1'b0, (i != 0) ? w : '0);
      rd32(ea(1'b0, FGPIO_OFS_IRQ_STAT), 1'b0, 32'h1 << pt);
      wr32(ea(hi, FGPIO_OFS_EDGE_CLR), w);
      tick(2);
      chk("irq", 1'b0, irq);
      rd32(ea(hi, FGPIO_OFS_RISE_STAT), 1'b0, '0);
    end
    $display("test edge done");
    wr32(ea(1'b1, FGPIO_OFS_RISE_EN), 32'h1);
    @(posedge pclk);
    ce <= 1'b0;
    ext_drv[2] <= 32'h1;
    #5;
    chk("wake", 1'b1, wake);
    @(posedge pclk);
    ce <= 1'b1;
    tick(6);
    wr32(ea(1'b1, FGPIO_OFS_EDGE_CLR), 32'h1);
    ext_irq <= 1'b1;
    tick(3);
    chk("irq", 1'b1, irq);
    ext_irq <= 1'b0;
    rd32(12'hF00, 1'b1, '0);
    wr32(12'hF04, $random(seed));
    $display("test wake done");
    tick(2);
    chk("queue", 0, exp_q.size());
    results();
  end
endmodule
